/* hw/hbst_pkg.sv */
`default_nettype none
package hbst_pkg;
	// Register byte addresses
	localparam logic [15:0] OFF_BLANK_POS = 16'h8334;
	localparam logic [15:0] OFF_SYNC_POS  = 16'h8338;
	localparam logic [15:0] OFF_CONTROL   = 16'h8300;
	// Field positions
	localparam int HI_MSB     = 26;
	localparam int HI_LSB     = 19;
	localparam int LO_MSB     = 10;
	localparam int LO_LSB     = 3;
	localparam int LOCK_BIT   = 0;
	// Reset value, field mask and response codes
	localparam logic [7:0]  POS_RESET  = 8'h00;
	localparam logic [31:0] FIELD_MASK = 32'h07f8_07f8;
	localparam logic [1:0]  RESP_OKAY  = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic hblank;
		logic hsync;
		logic line_advance;
	} hbst_video_t;
endpackage
`default_nettype wire

/* hw/hbst_timing.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] Blank asserts when character count equals blank start field plus one.
// [R2] Software keeps blanking at least four character clocks long.
// [R3] Sync deasserts when character count equals sync end field plus one.
// [R4] Sync asserts when character count equals sync start field plus one.
// [R5] Each sync transition pulses the vertical line advance output.
// [R6] Timing position writes ignored while locked; reserved bits read zero.
module hbst_timing (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Timing interface
	input  wire logic [7:0]         char_count,
	input  wire logic               blank_end_hit,
	output var  hbst_pkg::hbst_video_t video,
	// AXI4-Lite write
	input  wire logic [15:0]        s_awaddr,
	input  wire logic               s_awvalid,
	output logic                    s_awready,
	input  wire logic [31:0]        s_wdata,
	input  wire logic [3:0]         s_wstrb,
	input  wire logic               s_wvalid,
	output logic                    s_wready,
	output logic [1:0]              s_bresp,
	output logic                    s_bvalid,
	input  wire logic               s_bready,
	// AXI4-Lite read
	input  wire logic [15:0]        s_araddr,
	input  wire logic               s_arvalid,
	output logic                    s_arready,
	output logic [31:0]             s_rdata,
	output logic [1:0]              s_rresp,
	output logic                    s_rvalid,
	input  wire logic               s_rready
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]  hblank_begin_pos;
	logic [7:0]  hblank_end_pos;
	logic [7:0]  hsync_begin_pos;
	logic [7:0]  hsync_end_pos;
	logic        lock;
	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	wire do_write  = aw_held && w_held && !s_bvalid;
	wire hit_blank = aw_addr == hbst_pkg::OFF_BLANK_POS;
	wire hit_sync  = aw_addr == hbst_pkg::OFF_SYNC_POS;
	wire hit_ctrl  = aw_addr == hbst_pkg::OFF_CONTROL;
	wire hit_any   = hit_blank || hit_sync || hit_ctrl;
	// Timing positions only change when unlocked, so a live display is safe
	wire wr_timing = do_write && !lock; // [R6]
	wire wr_lo     = w_strb[1] && w_strb[0];
	wire wr_hi     = w_strb[3] && w_strb[2];
	// Low field bits are dropped, pixel counts act on 8-pixel boundaries
	wire [7:0] lo_field = w_data[hbst_pkg::LO_MSB:hbst_pkg::LO_LSB]; // [R1] [R4]
	wire [7:0] hi_field = w_data[hbst_pkg::HI_MSB:hbst_pkg::HI_LSB]; // [R3]

	always_ff @(posedge clock) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 16'h0000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_held <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= hbst_pkg::RESP_OKAY;
		end else begin
			s_awready <= !aw_held && !(s_awvalid && s_awready);
			s_wready  <= !w_held && !(s_wvalid && s_wready);
			if (do_write) begin
				s_bvalid <= 1'b1;
				s_bresp  <= hit_any ? hbst_pkg::RESP_OKAY : hbst_pkg::RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			hblank_begin_pos <= hbst_pkg::POS_RESET;
			hblank_end_pos   <= hbst_pkg::POS_RESET;
			hsync_begin_pos  <= hbst_pkg::POS_RESET;
			hsync_end_pos    <= hbst_pkg::POS_RESET;
			lock             <= 1'b0;
		end else begin
			if (do_write && hit_ctrl && w_strb[0])
				lock <= w_data[hbst_pkg::LOCK_BIT];
			if (wr_timing && hit_blank && wr_lo)
				hblank_begin_pos <= lo_field;
			if (wr_timing && hit_blank && wr_hi)
				hblank_end_pos <= hi_field;
			if (wr_timing && hit_sync && wr_lo)
				hsync_begin_pos <= lo_field;
			if (wr_timing && hit_sync && wr_hi)
				hsync_end_pos <= hi_field;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	wire [31:0] rd_blank = {5'h00, hblank_end_pos, 3'h0, 5'h00, hblank_begin_pos, 3'h0}; // [R6]
	wire [31:0] rd_sync  = {5'h00, hsync_end_pos, 3'h0, 5'h00, hsync_begin_pos, 3'h0};
	wire [31:0] rd_ctrl  = {31'h0000_0000, lock};
	wire        rd_ok    = s_araddr == hbst_pkg::OFF_BLANK_POS || s_araddr == hbst_pkg::OFF_SYNC_POS
		|| s_araddr == hbst_pkg::OFF_CONTROL;
	wire [31:0] rd_mux   = (s_araddr == hbst_pkg::OFF_BLANK_POS) ? rd_blank :
		(s_araddr == hbst_pkg::OFF_SYNC_POS) ? rd_sync :
		(s_araddr == hbst_pkg::OFF_CONTROL) ? rd_ctrl : 32'h0000_0000;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= hbst_pkg::RESP_OKAY;
		end else begin
			s_arready <= !s_rvalid && !(s_arvalid && s_arready);
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_mux;
				s_rresp  <= rd_ok ? hbst_pkg::RESP_OKAY : hbst_pkg::RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Blank and sync generation
	// ----------------------------------------
	// Blank interval of under four clocks is not guarded here; software keeps it [R2]
	wire hit_blank_start = char_count == hblank_begin_pos + 8'h01; // [R1]
	wire hit_sync_start  = char_count == hsync_begin_pos + 8'h01;  // [R4]
	wire hit_sync_end    = char_count == hsync_end_pos + 8'h01;    // [R3]
	wire next_hblank     = hit_blank_start ? 1'b1 : (blank_end_hit ? 1'b0 : video.hblank);
	wire next_hsync      = hit_sync_start ? 1'b1 : (hit_sync_end ? 1'b0 : video.hsync);
	wire next_advance    = next_hsync != video.hsync; // [R5]

	always_ff @(posedge clock) begin
		if (!resetn) begin
			video <= '0;
		end else begin
			video.hblank       <= next_hblank;
			video.hsync        <= next_hsync;
			video.line_advance <= next_advance;
		end
	end

	a_blank_start: assert property (@(posedge clock) disable iff (!resetn) // [R1]
		hit_blank_start |=> video.hblank)
		else $error("blank not raised at start position");
	a_sync_start: assert property (@(posedge clock) disable iff (!resetn) // [R4]
		hit_sync_start |=> video.hsync)
		else $error("sync not raised at start position");
	a_sync_end: assert property (@(posedge clock) disable iff (!resetn) // [R3]
		(hit_sync_end && !hit_sync_start) |=> !video.hsync)
		else $error("sync not dropped at end position");
	a_line_adv: assert property (@(posedge clock) disable iff (!resetn) // [R5]
		(video.hsync != $past(video.hsync)) |-> video.line_advance)
		else $error("line advance missing on sync edge");
	a_lock_hold: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		lock |=> $stable(hsync_begin_pos) && $stable(hblank_begin_pos))
		else $error("timing changed while locked");
	a_adv_pulse: assert property (@(posedge clock) disable iff (!resetn) // [R5]
		video.line_advance |-> (video.hsync != $past(video.hsync)))
		else $error("line advance without sync edge");
	a_sync_quiet: assert property (@(posedge clock) disable iff (!resetn) // [R3] [R4]
		(!hit_sync_start && !hit_sync_end) |=> $stable(video.hsync))
		else $error("sync moved away from its positions");
	a_blank_quiet: assert property (@(posedge clock) disable iff (!resetn) // [R1]
		(!hit_blank_start && !blank_end_hit) |=> $stable(video.hblank))
		else $error("blank moved without start or end");
	a_blank_end: assert property (@(posedge clock) disable iff (!resetn) // [R1]
		(blank_end_hit && !hit_blank_start) |=> !video.hblank)
		else $error("blank not dropped at blank end");

	// ----------------------------------------
	// Register bus checks
	// ----------------------------------------
	a_reserved_zero: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		s_rvalid |-> (s_rdata[31:27] == 5'h00 && s_rdata[15:11] == 5'h00))
		else $error("reserved bits read nonzero");
	a_lock_ends: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		lock |=> $stable(hsync_end_pos) && $stable(hblank_end_pos))
		else $error("end positions changed while locked");
	a_read_err: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		(s_arvalid && s_arready && !rd_ok) |=> (s_rresp == hbst_pkg::RESP_SLVERR && s_rdata == 32'h0000_0000))
		else $error("unmapped read not refused");
	a_write_err: assert property (@(posedge clock) disable iff (!resetn) // [R6]
		(do_write && !hit_any) |=> (s_bvalid && s_bresp == hbst_pkg::RESP_SLVERR))
		else $error("unmapped write not refused");
endmodule
`default_nettype wire

/* verification/hbst_display_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Monitor side: counts lines as the display sees them
module hbst_display_model (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  resetn,
	// Video from the block
	input  wire hbst_pkg::hbst_video_t video,
	output logic [15:0]                lines
);
	always_ff @(posedge clock) begin
		if (!resetn)
			lines <= 16'h0000;
		else if (video.line_advance)
			lines <= lines + 16'h0001;
	end
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clock = 1'b0, resetn = 1'b0, end_hit = 1'b0;
	logic [7:0] char_count = 8'h00;
	hbst_pkg::hbst_video_t video;
	logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, lines;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0] strb = 4'hf;
	logic [1:0] bresp, rresp, r;
	int failures = 0, tests_run = 0, cycles = 0;
	hbst_timing uut (.clock(clock), .resetn(resetn), .char_count(char_count),
		.blank_end_hit(end_hit), .video(video), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(strb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
	hbst_display_model mon (.clock(clock), .resetn(resetn), .video(video), .lines(lines));
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			conclude;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= v;
		strb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clock);
			if (awvalid && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task rd(input logic [15:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task t_regs;
		rd(hbst_pkg::OFF_SYNC_POS);
		chk(d, 32'h0);
		rd(16'h8400);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, hbst_pkg::RESP_SLVERR});
		wr(16'h8400, 32'h0000_0001, 4'hf);
		chk({30'h0, r}, {30'h0, hbst_pkg::RESP_SLVERR});
		wr(hbst_pkg::OFF_BLANK_POS, 32'hffff_002f, 4'hf);
		chk({30'h0, r}, {30'h0, hbst_pkg::RESP_OKAY});
		rd(hbst_pkg::OFF_BLANK_POS);
		chk(d, 32'h07f8_0028);
		wr(hbst_pkg::OFF_SYNC_POS, 32'h00a7_0057, 4'hf);
		rd(hbst_pkg::OFF_SYNC_POS);
		chk(d, 32'h00a0_0050);
		$display("test regs done");
	endtask
	// Blank from 6, sync from 11 to 21, then blank end after at least four clocks
	// Video read at an edge answers the count sampled one edge earlier
	task t_sweep;
		for (int c = 0; c <= 32; c++) begin
			if (c < 32) char_count <= c[7:0];
			@(posedge clock);
			if (c > 0) chk({29'h0, video}, {29'h0, c > 6, c > 11 && c < 22, c == 12 || c == 22});
		end
		end_hit <= 1'b1;
		@(posedge clock);
		end_hit <= 1'b0;
		@(posedge clock);
		chk({31'h0, video.hblank}, 32'h0);
		chk({16'h0, lines}, 32'h2);
		$display("test sweep done");
	endtask
	task t_lock;
		@(posedge clock);
		wr(hbst_pkg::OFF_SYNC_POS, 32'h00f8_0018, 4'h3);
		rd(hbst_pkg::OFF_SYNC_POS);
		chk(d, 32'h00a0_0018);
		wr(hbst_pkg::OFF_CONTROL, 32'h1, 4'hf);
		rd(hbst_pkg::OFF_CONTROL);
		chk(d, 32'h0000_0001);
		wr(hbst_pkg::OFF_SYNC_POS, 32'h0000_0008, 4'hf);
		chk({30'h0, r}, {30'h0, hbst_pkg::RESP_OKAY});
		rd(hbst_pkg::OFF_SYNC_POS);
		chk(d, 32'h00a0_0018);
		$display("test lock done");
	endtask
	task conclude;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_regs;
		t_sweep;
		t_lock;
		conclude;
	end
endmodule
`default_nettype wire
